// ---- rtl/lifo_stack_cfg.svh ----
// Constants of the stack engine: capacity, register offsets,
// field positions and reset values.
// Assumes inclusion by bare name from every design file.
`ifndef LIFO_STACK_CFG_SVH
`define LIFO_STACK_CFG_SVH

// ************************************************************
// Sizes
// ************************************************************
`define LIFO_DATA_W      16
`define LIFO_IDX_W       5
`define LIFO_CAP         5'h10
`define LIFO_DEPTH       17

// ************************************************************
// Register offsets (byte addresses)
// ************************************************************
`define LIFO_ADDR_W      8
`define OFS_CTRL         8'h00
`define OFS_INDEX        8'h04
`define OFS_FLAGS        8'h08
`define OFS_EVT_STAT     8'h0C
`define OFS_EVT_MASK     8'h10

// ************************************************************
// Field positions
// ************************************************************
`define CTRL_PULSE_BIT   0
`define FLG_EMPTY_BIT    0
`define FLG_FULL_BIT     1
`define FLG_ERR_BIT      2
`define EVT_PUSH_BIT     0
`define EVT_POP_BIT      1
`define EVT_REFUSE_BIT   2
`define EVT_ERR_BIT      3
`define EVT_W            4

// ************************************************************
// Reset values
// ************************************************************
`define RST_CTRL         1'h0
`define RST_INDEX        5'h00
`define RST_EVT          4'h0
`define RST_WORD         16'h0000

`endif

// ---- rtl/lifo_stack_pkg.sv ----
// Types shared by the stack engine and its storage.
// Assumes lifo_stack_cfg.svh is on the include path.
`include "lifo_stack_cfg.svh"

package lifo_stack_pkg;
    typedef logic [`LIFO_DATA_W-1:0] word_t;
    typedef logic [`LIFO_IDX_W-1:0]  idx_t;
    // Decoded operation of one cycle, one-hot
    typedef enum logic [3:0] {
        OP_IDLE = 4'h1,
        OP_PUSH = 4'h2,
        OP_POP  = 4'h4,
        OP_HOLD = 4'h8
    } op_t;
endpackage

// ---- rtl/lifo_stack_unit.sv ----
// Last-in-first-out stack engine with a small register port.
// Assumes enable, select and push data come from logic on clk.
`timescale 1ns/1ps
`include "lifo_stack_cfg.svh"

// How it works
// [RULE1] Operate while enable is high, or only on its rising edge in pulse mode.
// [RULE2] Select high pushes the input word; select low pops into the output.
// [RULE3] A push first raises the top index, then writes the new top word.
// [RULE4] A pop copies the word at the current top index to the output.
// [RULE5] After the pop transfer the top index drops by one.
// [RULE6] The top index always names the most recently pushed word.
// [RULE7] Empty flag is high whenever the top index is zero.
// [RULE8] Pops while empty are ignored; index and output stay.
// [RULE9] Full flag is high when the top index equals the capacity.
// [RULE10] Pushes while full are ignored; index and words stay.
// [RULE11] Index zero means empty; one to capacity select storage words.
// [RULE12] Index beyond capacity raises pointer error and blocks every operation.
// [RULE13] Controlling logic leaves the index alone except for special purposes.
// [RULE14] Idle cycles change nothing; reset clears the index to empty.
// [RULE15] Words are sixteen bits; capacity is a fixed configuration constant.
module lifo_stack_unit (
    input  wire logic                    clk,            // System clock
    input  wire logic                    sys_rst,        // Sync reset, high
    input  wire logic                    exec_en,        // Execution control
    input  wire logic                    push_sel,       // 1 push, 0 pop
    input  wire lifo_stack_pkg::word_t   push_value,     // Word to push
    input  wire logic [`LIFO_ADDR_W-1:0] reg_addr,       // Register address
    input  wire logic [31:0]             reg_wdata,      // Write data
    input  wire logic                    reg_wr,         // Write strobe
    input  wire logic                    reg_rd,         // Read strobe
    output logic [31:0]                  reg_rdata,      // Read data, next cycle
    output lifo_stack_pkg::word_t        pop_result,     // Last popped word
    output logic                         empty_flag,     // Stack empty
    output logic                  capacity_reached_flag, // Stack full
    output logic                         ptr_err_flag,   // Index out of range
    output logic                         irq             // Level interrupt
);

    // ************************************************************
    // State
    // ************************************************************
    lifo_stack_pkg::idx_t  top_index_q;
    lifo_stack_pkg::idx_t  top_index_d;
    lifo_stack_pkg::word_t top_word;                          // RULE15
    logic                  pulse_mode_q;
    logic                  en_prev_q;
    logic [`EVT_W-1:0]     evt_stat_q;
    logic [`EVT_W-1:0]     evt_mask_q;
    logic [`EVT_W-1:0]     evt_set;
    logic [`EVT_W-1:0]     evt_clr;

    // ************************************************************
    // Decode
    // ************************************************************
    // Level or rising-edge qualification of the request
    wire logic go = pulse_mode_q ? (exec_en && !en_prev_q)   // RULE1
                                 : exec_en;
    wire logic idx_bad = top_index_q > `LIFO_CAP;             // RULE11
    wire logic is_empty = top_index_q == `RST_INDEX;
    wire logic is_full = top_index_q == `LIFO_CAP;
    wire logic wr_ctrl = reg_wr && reg_addr == `OFS_CTRL;
    wire logic wr_index = reg_wr && reg_addr == `OFS_INDEX;
    wire logic wr_stat = reg_wr && reg_addr == `OFS_EVT_STAT;
    wire logic wr_mask = reg_wr && reg_addr == `OFS_EVT_MASK;

    // Software index write wins over a same-cycle operation
    lifo_stack_pkg::op_t op;
    always_comb begin
        if (!go || wr_index) begin
            op = lifo_stack_pkg::OP_IDLE;                     // RULE14
        end else if (idx_bad) begin
            op = lifo_stack_pkg::OP_HOLD;                     // RULE12
        end else if (push_sel) begin
            op = is_full ? lifo_stack_pkg::OP_HOLD            // RULE10
                         : lifo_stack_pkg::OP_PUSH;           // RULE2
        end else begin
            op = is_empty ? lifo_stack_pkg::OP_HOLD           // RULE8
                          : lifo_stack_pkg::OP_POP;           // RULE2
        end
    end

    wire logic do_push = op == lifo_stack_pkg::OP_PUSH;
    wire logic do_pop = op == lifo_stack_pkg::OP_POP;
    wire logic refused = op == lifo_stack_pkg::OP_HOLD && !idx_bad;
    wire logic blocked = op == lifo_stack_pkg::OP_HOLD && idx_bad;

    // Next top index
    always_comb begin
        case (op)
            lifo_stack_pkg::OP_PUSH: top_index_d = top_index_q + 5'h01; // RULE3
            lifo_stack_pkg::OP_POP:  top_index_d = top_index_q - 5'h01; // RULE5
            default: begin
                top_index_d = wr_index ? reg_wdata[`LIFO_IDX_W-1:0]   // RULE13
                                       : top_index_q;
            end
        endcase
    end

    // ************************************************************
    // Storage
    // ************************************************************
    // Read port follows the next index, so top_word is the live top
    lifo_store_mem u_store (
        .clk   (clk),
        .we    (do_push),                                     // RULE3
        .waddr (top_index_d),
        .wdata (push_value),
        .raddr (top_index_d),                                 // RULE6
        .rdata (top_word)
    );

    // ************************************************************
    // Engine registers
    // ************************************************************
    // Index, output word and flags; flags follow the next index
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            top_index_q           <= `RST_INDEX;              // RULE14
            pop_result            <= `RST_WORD;
            en_prev_q             <= 1'b0;
            empty_flag            <= 1'b1;
            capacity_reached_flag <= 1'b0;
            ptr_err_flag          <= 1'b0;
        end else begin
            top_index_q           <= top_index_d;
            en_prev_q             <= exec_en;
            if (do_pop) begin
                pop_result <= top_word;                       // RULE4
            end
            empty_flag            <= top_index_d == `RST_INDEX; // RULE7
            capacity_reached_flag <= top_index_d == `LIFO_CAP;  // RULE9
            ptr_err_flag          <= top_index_d > `LIFO_CAP;   // RULE12
        end
    end

    // ************************************************************
    // Register port and interrupt
    // ************************************************************
    // Set beats a same-cycle write-one clear
    assign evt_set = {blocked, refused, do_pop, do_push};
    assign evt_clr = wr_stat ? reg_wdata[`EVT_W-1:0] : `RST_EVT;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pulse_mode_q <= `RST_CTRL;
            evt_stat_q   <= `RST_EVT;
            evt_mask_q   <= `RST_EVT;
            irq          <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                pulse_mode_q <= reg_wdata[`CTRL_PULSE_BIT];
            end
            if (wr_mask) begin
                evt_mask_q <= reg_wdata[`EVT_W-1:0];
            end
            evt_stat_q <= (evt_stat_q & ~evt_clr) | evt_set;
            irq <= |(((evt_stat_q & ~evt_clr) | evt_set) & evt_mask_q);
        end
    end

    // Read mux; unmapped offsets read zero
    logic [31:0] rd_mux;
    always_comb begin
        case (reg_addr)
            `OFS_CTRL:     rd_mux = {31'h0, pulse_mode_q};
            `OFS_INDEX:    rd_mux = {27'h0, top_index_q};
            `OFS_FLAGS:    rd_mux = {29'h0, ptr_err_flag,
                                     capacity_reached_flag, empty_flag};
            `OFS_EVT_STAT: rd_mux = {28'h0, evt_stat_q};
            `OFS_EVT_MASK: rd_mux = {28'h0, evt_mask_q};
            default:       rd_mux = 32'h0;
        endcase
    end

    // Data valid only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst || !reg_rd) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= rd_mux;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_pulse_once;
        pulse_mode_q && exec_en && $past(exec_en) |-> !go;
    endproperty
    a_pulse_once: assert property (p_pulse_once) // RULE1
        else $error("pulse mode ran on a held enable");

    property p_push_up;
        go && push_sel && !wr_index && !idx_bad && !is_full
            |=> top_index_q == $past(top_index_q) + 5'h01;
    endproperty
    a_push_up: assert property (p_push_up) // RULE3
        else $error("push did not raise the index");

    property p_pop_word;
        do_pop |=> pop_result == $past(top_word)
                   && top_index_q == $past(top_index_q) - 5'h01;
    endproperty
    a_pop_word: assert property (p_pop_word) // RULE5
        else $error("pop gave wrong word or index");

    property p_lifo;
        do_push ##1 do_pop |=> pop_result == $past(push_value, 2);
    endproperty
    a_lifo: assert property (p_lifo) // RULE6
        else $error("pop did not return last pushed word");

    property p_empty;
        empty_flag == (top_index_q == `RST_INDEX);
    endproperty
    a_empty: assert property (p_empty) // RULE7
        else $error("empty flag disagrees with index");

    property p_pop_empty;
        go && !push_sel && is_empty && !wr_index
            |=> $stable(top_index_q) && $stable(pop_result);
    endproperty
    a_pop_empty: assert property (p_pop_empty) // RULE8
        else $error("pop on empty changed state");

    property p_full;
        capacity_reached_flag == (top_index_q == `LIFO_CAP);
    endproperty
    a_full: assert property (p_full) // RULE9
        else $error("full flag disagrees with index");

    property p_push_full;
        go && push_sel && is_full && !wr_index |=> $stable(top_index_q);
    endproperty
    a_push_full: assert property (p_push_full) // RULE10
        else $error("push on full changed index");

    property p_err;
        ptr_err_flag |-> !do_push && !do_pop;
    endproperty
    a_err: assert property (p_err) // RULE12
        else $error("operation ran with bad index");

    property p_idle;
        !go && !wr_index |=> $stable(top_index_q) && $stable(pop_result);
    endproperty
    a_idle: assert property (p_idle) // RULE14
        else $error("idle cycle changed state");

    property p_irq;
        irq |-> $past(evt_mask_q) != `RST_EVT;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt with every event masked");

    // Forwarded write keeps the read port on the new top word
    property p_push_word;
        do_push |=> top_word == $past(push_value);
    endproperty
    a_push_word: assert property (p_push_word) // RULE3
        else $error("pushed word is not the new top");

    // Output word moves only on an accepted pop
    property p_pop_hold;
        !do_pop |=> $stable(pop_result);
    endproperty
    a_pop_hold: assert property (p_pop_hold) // RULE4
        else $error("output word moved without a pop");

    // A bad index freezes the stack until software repairs it
    property p_err_block;
        go && idx_bad && !wr_index |=> $stable(top_index_q) && ptr_err_flag;
    endproperty
    a_err_block: assert property (p_err_block) // RULE12
        else $error("bad index did not block the operation");

    // An event is never lost to a write-one clear in the same cycle
    property p_set_wins;
        evt_set != `RST_EVT |=> (evt_stat_q & $past(evt_set)) == $past(evt_set);
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost to a same-cycle clear");

    // With a settled mask, any unmasked event holds the interrupt up
    property p_irq_on;
        $stable(evt_mask_q) && (evt_stat_q & evt_mask_q) != `RST_EVT |-> irq;
    endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("unmasked event without interrupt");

    // Read data stand only in the cycle after a read strobe
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside the read cycle");

    c_fill: cover property (do_push ##1 capacity_reached_flag);
    c_drain: cover property (do_pop ##1 empty_flag);
    c_lifo: cover property (do_push ##1 do_pop);
    c_err: cover property (blocked);
    c_pulse: cover property (pulse_mode_q && do_push);

endmodule // lifo_stack_unit

// ---- rtl/lifo_store_mem.sv ----
// Storage words of the stack: one write port, one registered read.
// Assumes one clock; read address is the next top index.
`timescale 1ns/1ps
`include "lifo_stack_cfg.svh"

module lifo_store_mem (
    input  wire logic                 clk,    // System clock
    input  wire logic                 we,     // Write strobe
    input  wire lifo_stack_pkg::idx_t waddr,  // Write address
    input  wire lifo_stack_pkg::word_t wdata, // Write data
    input  wire lifo_stack_pkg::idx_t raddr,  // Read address
    output lifo_stack_pkg::word_t     rdata   // Registered read data
);
    lifo_stack_pkg::word_t mem [0:`LIFO_DEPTH-1];

    // Forward a same-cycle write so rdata always mirrors the top
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        if (we && waddr == raddr) begin
            rdata <= wdata;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule // lifo_store_mem

// ---- testbench/lifo_ctrl_model.sv ----
// Controlling logic in front of the stack engine: turns bench commands
// into registered execution control, select and push data.
// Assumes the bench drives commands on the rising edge of clk.
`timescale 1ns/1ps

module lifo_ctrl_model (
    input  wire logic                   clk,        // System clock
    input  wire logic                   sys_rst,    // Sync reset, high
    input  wire logic                   cmd_valid,  // Bench wants an operation
    input  wire logic                   cmd_push,   // 1 push, 0 pop
    input  wire lifo_stack_pkg::word_t  cmd_value,  // Word to push
    output lifo_stack_pkg::word_t       push_value, // Data towards the engine
    output logic                        exec_en,    // Execution control
    output logic                        push_sel    // Push or pop select
);
    // Registered drive; data toggles when unused so stale words never pass
    // The index is never written from here, only by the bench for tests
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            exec_en    <= 1'h0;
            push_sel   <= 1'h0;
            push_value <= 16'h0000;
        end else begin
            exec_en    <= cmd_valid;
            push_sel   <= cmd_push;
            push_value <= cmd_valid ? cmd_value : ~push_value;
        end
    end
endmodule // lifo_ctrl_model

// ---- testbench/lifo_stack_unit_bench.sv ----
// Self-checking bench of the stack engine with a reference stack.
// Assumes lifo_stack_cfg.svh on the include path and the design files.
`timescale 1ns/1ps
`include "lifo_stack_cfg.svh"

module lifo_stack_unit_bench;
    logic clk, sys_rst, cmd_valid, cmd_push, reg_wr, reg_rd;
    logic exec_en, push_sel, empty_flag, full_flag, ptr_err_flag, irq;
    lifo_stack_pkg::word_t cmd_value, push_value, pop_result, m_pop, v;
    lifo_stack_pkg::word_t mem [0:31];
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd;
    logic [4:0]  m_idx;
    logic [3:0]  m_evt, m_mask;
    logic        m_pulse;
    int          miscompares, n_compared, n;

    // ************************************************************
    // Clock, parts
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    lifo_ctrl_model i_ctrl (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_push(cmd_push), .cmd_value(cmd_value), .push_value(push_value),
        .exec_en(exec_en), .push_sel(push_sel));

    lifo_stack_unit i_dut (.clk(clk), .sys_rst(sys_rst), .exec_en(exec_en),
        .push_sel(push_sel), .push_value(push_value), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pop_result(pop_result), .empty_flag(empty_flag),
        .capacity_reached_flag(full_flag), .ptr_err_flag(ptr_err_flag), .irq(irq));

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (miscompares == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Reference stack: one call per executed cycle
    function automatic void apply(input logic p, input lifo_stack_pkg::word_t w);
        if (m_idx > `LIFO_CAP) m_evt[`EVT_ERR_BIT] = 1'b1;
        else if (p && m_idx == `LIFO_CAP) m_evt[`EVT_REFUSE_BIT] = 1'b1;
        else if (!p && m_idx == 5'h00) m_evt[`EVT_REFUSE_BIT] = 1'b1;
        else if (p) begin
            m_idx = m_idx + 5'h01;
            mem[m_idx] = w;
            m_evt[`EVT_PUSH_BIT] = 1'b1;
        end else begin
            m_pop = mem[m_idx];
            m_idx = m_idx - 5'h01;
            m_evt[`EVT_POP_BIT] = 1'b1;
        end
    endfunction

    // Hold the command k cycles; level mode runs k operations, pulse mode one
    task automatic do_op(input logic p, input lifo_stack_pkg::word_t w, input int k);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_push  <= p;
        cmd_value <= w;
        repeat (k) @(posedge clk);
        cmd_valid <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < (m_pulse ? 1 : k); i++) apply(p, w);
        #1 chk(pop_result, m_pop);
        chk(empty_flag, m_idx == 5'h00);
        chk(full_flag, m_idx == `LIFO_CAP);
        chk(ptr_err_flag, m_idx > `LIFO_CAP);
        reg_read(`OFS_INDEX, rd);
        chk(rd, {27'h0, m_idx});
        reg_read(`OFS_EVT_STAT, rd);
        chk(rd, {28'h0, m_evt});
        chk(irq, |(m_evt & m_mask));
    endtask

    task automatic set_reg(input logic [7:0] a, input logic [31:0] d);
        reg_write(a, d);
        if (a == `OFS_INDEX) m_idx = d[4:0];
        if (a == `OFS_CTRL) m_pulse = d[0];
        if (a == `OFS_EVT_MASK) m_mask = d[3:0];
        if (a == `OFS_EVT_STAT) m_evt = m_evt & ~d[3:0];
    endtask

    // ************************************************************
    // Watchdog and main sequence
    // ************************************************************
    initial begin
        #(40 * 20000);
        miscompares++;
        results();
    end

    initial begin
        {cmd_valid, cmd_push, reg_wr, reg_rd} = 4'h0;
        cmd_value = 16'h0000;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        sys_rst = 1'b1;
        {m_idx, m_evt, m_mask, m_pulse, m_pop} = '0;
        miscompares = 0;
        n_compared = 0;
        void'($urandom(32'hC2A8AB2A));
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        reg_read(`OFS_FLAGS, rd);
        chk(rd, 32'h1);
        reg_read(`OFS_INDEX, rd);
        chk(rd, 32'h0);
        reg_read(`OFS_CTRL, rd);
        chk(rd, 32'h0);
        reg_read(8'h40, rd);
        chk(rd, 32'h0);
        // Refused pop raises a masked-in interrupt; after a clear, two more refused pops raise it again
        set_reg(`OFS_EVT_MASK, 32'h4);
        do_op(1'b0, 16'h0000, 1);
        set_reg(`OFS_EVT_STAT, 32'hF);
        do_op(1'b0, 16'h0000, 2);
        set_reg(`OFS_EVT_MASK, 32'h0);
        // Fill to capacity, one more refused, then empty in reverse order
        for (int i = 0; i < 17; i++) do_op(1'b1, 16'($urandom), 1);
        for (int i = 0; i < 17; i++) do_op(1'b0, 16'h0000, 1);
        // Out of range index blocks work; a legal write resumes it
        set_reg(`OFS_INDEX, 32'h11);
        do_op(1'b1, 16'hA5A5, 1);
        do_op(1'b0, 16'h0000, 1);
        set_reg(`OFS_INDEX, 32'h3);
        do_op(1'b0, 16'h0000, 1);
        // Pulse mode runs once per rising edge of the control
        set_reg(`OFS_CTRL, 32'h1);
        do_op(1'b1, 16'h1234, 3);
        set_reg(`OFS_CTRL, 32'h0);
        do_op(1'b1, 16'h4321, 3);
        // Random mix with back-to-back level operations
        set_reg(`OFS_EVT_MASK, 32'($urandom % 16));
        for (int i = 0; i < 60; i++) begin
            n = 1 + $urandom % 3;
            v = 16'($urandom);
            do_op(1'($urandom % 2), v, n);
            if (i % 10 == 9) set_reg(`OFS_EVT_STAT, 32'($urandom % 16));
        end
        // Reset in mid-run empties a loaded stack and clears index, event status, output word and interrupt
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        {m_idx, m_evt, m_mask, m_pulse, m_pop} = '0;
        @(posedge clk);
        #1 chk(pop_result, 16'h0000);
        chk(irq, 1'b0);
        reg_read(`OFS_FLAGS, rd);
        chk(rd, 32'h1);
        reg_read(`OFS_INDEX, rd);
        chk(rd, 32'h0);
        reg_read(`OFS_EVT_STAT, rd);
        chk(rd, 32'h0);
        do_op(1'b1, 16'h5A5A, 1);
        do_op(1'b0, 16'h0000, 1);
        results();
    end
endmodule // lifo_stack_unit_bench
